// File: pkg/sync_trig_pkg.sv
// Constants and types for the two-channel downlink sync trigger block
package sync_trig_pkg;

	localparam int BUF_BITS = 64;
	localparam int CNT_W    = 7;
	localparam int TMR_W    = 16;
	localparam int CTRL_W   = 16;

	// Buffer reset words on the device control register
	localparam logic [CTRL_W-1:0] RESET_CH1 = 16'h00ff;
	localparam logic [CTRL_W-1:0] RESET_CH2 = 16'hff00;

	// Pulse lengths in clock cycles of 4 ns
	localparam int CLK_NS       = 4;
	localparam int SHORT_NS     = 1000;
	localparam int LONG_NS      = 2000;
	localparam int SHORT_CYCLES = SHORT_NS / CLK_NS;
	localparam int LONG_CYCLES  = LONG_NS / CLK_NS;
	localparam int PLEN_W       = 10;
	localparam logic [PLEN_W-1:0] SHORT_LEN = PLEN_W'(SHORT_CYCLES);
	localparam logic [PLEN_W-1:0] LONG_LEN  = PLEN_W'(LONG_CYCLES);

	// Trigger sources
	typedef enum logic [2:0] {
		SRC_CMD_NOBUF = 3'h0,
		SRC_CMD_BUF   = 3'h1,
		SRC_PIN_NOBUF = 3'h2,
		SRC_PIN_BUF   = 3'h3,
		SRC_TIMER     = 3'h4
	} src_e;

	localparam src_e SRC_RESET = SRC_PIN_NOBUF;

	typedef enum logic [1:0] {
		PST_IDLE  = 2'b00,
		PST_PULSE = 2'b01
	} pst_e;

endpackage

// File: logic/pulse_channel.sv
// One channel: shift buffer, trigger filter and pulse timer
`timescale 1ns/1ps
`default_nettype none
module pulse_channel (
	// Clock and reset
	input  wire logic                                    clk,
	input  wire logic                                    rst,
	// Configuration
	input  wire sync_trig_pkg::src_e                     source,
	input  wire logic                                    widthMode,
	input  wire logic                                    newRevision,
	input  wire logic                                    extLong,
	input  wire logic [sync_trig_pkg::TMR_W-1:0]         filterTime,
	// Buffer load and control
	input  wire logic                                    bufWrite,
	input  wire logic [sync_trig_pkg::BUF_BITS-1:0]      bufData,
	input  wire logic                                    readyConfirm,
	input  wire logic [sync_trig_pkg::CNT_W-1:0]         confirmLen,
	input  wire logic                                    bufReset,
	input  wire logic                                    faultClear,
	// Trigger events
	input  wire logic                                    cmdTrig,
	input  wire logic                                    pinRise,
	input  wire logic                                    timerTick,
	// Status
	output logic                                         busy,
	output logic                                         fault,
	output logic                                         pulseActive
);
	typedef struct packed {
		logic [sync_trig_pkg::BUF_BITS-1:0] shifter;
		logic [sync_trig_pkg::CNT_W-1:0]    left;
		logic                               busy;
		logic                               fault;
		logic [sync_trig_pkg::TMR_W-1:0]    guard;
		sync_trig_pkg::pst_e                pst;
		logic [sync_trig_pkg::PLEN_W-1:0]   plen;
	} ch_s;

	ch_s cur;
	ch_s next_cur;
	logic useBuf;
	logic trig;
	logic bitOut;

	always_comb begin
		next_cur = cur;
		useBuf = (source == sync_trig_pkg::SRC_CMD_BUF) ||
			(source == sync_trig_pkg::SRC_PIN_BUF) ||
			(source == sync_trig_pkg::SRC_TIMER);
		// Source select; timer ticks only count in timer mode
		case (source)
			sync_trig_pkg::SRC_CMD_NOBUF,
			sync_trig_pkg::SRC_CMD_BUF:   trig = cmdTrig;
			sync_trig_pkg::SRC_PIN_NOBUF,
			sync_trig_pkg::SRC_PIN_BUF:   trig = pinRise;
			sync_trig_pkg::SRC_TIMER:     trig = timerTick;
			default:                      trig = 1'b0;
		endcase
		bitOut = cur.shifter[sync_trig_pkg::BUF_BITS-1];
		if (cur.guard != '0)
			next_cur.guard = cur.guard - 1'b1;
		if (cur.pst == sync_trig_pkg::PST_PULSE) begin
			if (cur.plen <= 10'h001)
				next_cur.pst = sync_trig_pkg::PST_IDLE;
			else
				next_cur.plen = cur.plen - 1'b1;
		end
		// Filter window covers command and pin triggers
		if (trig && cur.guard == '0 &&
				source != sync_trig_pkg::SRC_TIMER) begin
			next_cur.guard = filterTime;
		end
		if (trig && (cur.guard == '0 ||
				source == sync_trig_pkg::SRC_TIMER)) begin
			if (!useBuf) begin
				// External side picks the length, long only on command
				next_cur.pst  = sync_trig_pkg::PST_PULSE;
				next_cur.plen = (extLong &&
					source == sync_trig_pkg::SRC_CMD_NOBUF) ?
					sync_trig_pkg::LONG_LEN : sync_trig_pkg::SHORT_LEN;
			end else if (!cur.busy) begin
				next_cur.pst  = sync_trig_pkg::PST_PULSE;
				next_cur.plen = sync_trig_pkg::SHORT_LEN;
			end else begin
				next_cur.shifter = {cur.shifter[sync_trig_pkg::BUF_BITS-2:0],
					1'b0};
				next_cur.left = cur.left - 1'b1;
				if (cur.left == 7'h01)
					next_cur.busy = 1'b0;
				if (widthMode && newRevision) begin
					next_cur.pst  = sync_trig_pkg::PST_PULSE;
					next_cur.plen = bitOut ? sync_trig_pkg::LONG_LEN :
						sync_trig_pkg::SHORT_LEN;
				end else if (bitOut) begin
					next_cur.pst  = sync_trig_pkg::PST_PULSE;
					next_cur.plen = sync_trig_pkg::SHORT_LEN;
				end
			end
		end
		// Clear first, so a fault event in the same cycle wins
		if (faultClear)
			next_cur.fault = 1'b0;
		// Trigger inside filter window while busy is refused
		if (trig && useBuf && cur.busy && cur.guard != '0 &&
				source != sync_trig_pkg::SRC_TIMER)
			next_cur.fault = 1'b1;
		if (bufWrite) begin
			if (cur.busy)
				next_cur.fault = 1'b1;
			else
				next_cur.shifter = bufData;
		end
		if (readyConfirm && !cur.busy && confirmLen != '0) begin
			next_cur.busy = 1'b1;
			next_cur.left = confirmLen;
		end
		if (bufReset) begin
			next_cur.shifter = '0;
			next_cur.busy = 1'b0;
			next_cur.left = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cur <= '{default: '0, pst: sync_trig_pkg::PST_IDLE};
		end else begin
			cur <= next_cur;
		end
	end

	assign busy        = cur.busy;
	assign fault       = cur.fault;
	assign pulseActive = (cur.pst == sync_trig_pkg::PST_PULSE);

	chk_write_while_busy: assert property (@(posedge clk)
		disable iff (rst) bufWrite && busy && !bufReset |=> fault)
		else $error("write while busy did not set fault");
	chk_busy_on_confirm: assert property (@(posedge clk)
		disable iff (rst) readyConfirm && !busy && confirmLen != '0 &&
		!bufReset |=> busy)
		else $error("busy did not rise on confirm");
	chk_reset_ready: assert property (@(posedge clk)
		disable iff (rst) bufReset |=> !busy)
		else $error("buffer reset left channel busy");
endmodule
`default_nettype wire

// File: logic/sync_pulse_downlink_trigger.sv
// Top of the two-channel downlink sync pulse trigger block
`timescale 1ns/1ps
`default_nettype none
module sync_pulse_downlink_trigger (
	// Clock and reset
	input  wire logic                                    clk,
	input  wire logic                                    rst,
	// Configuration
	input  wire logic                                    configWrite,
	input  wire logic [2:0]                              configSource1,
	input  wire logic [2:0]                              configSource2,
	input  wire logic [1:0]                              gapOrWidthSelect,
	input  wire logic                                    newRevision,
	input  wire logic [1:0]                              channelLongPulse,
	input  wire logic [sync_trig_pkg::TMR_W-1:0]         pulseIntervalTimerReg,
	input  wire logic [sync_trig_pkg::TMR_W-1:0]         interChannelPulseDelay,
	// Device control register write
	input  wire logic                                    deviceControlWrite,
	input  wire logic [sync_trig_pkg::CTRL_W-1:0]        deviceControlReg,
	// Buffer load, one channel per bit of the selects
	input  wire logic [1:0]                              bufferWrite,
	input  wire logic [sync_trig_pkg::BUF_BITS-1:0]      bufferData,
	input  wire logic [1:0]                              upstreamReadyConfirm,
	input  wire logic [sync_trig_pkg::CNT_W-1:0]         confirmLength,
	input  wire logic [1:0]                              faultClear,
	// Triggers
	input  wire logic [1:0]                              commandTrigger,
	input  wire logic                                    triggerPinOne,
	input  wire logic                                    triggerPinTwo,
	// Status and pulse outputs
	output logic [1:0]                                   upstreamBusyFlag,
	output logic [1:0]                                   upstreamWriteFault,
	output logic [1:0]                                   syncPulse,
	output logic [1:0]                                   receiverFreeze,
	output logic [2:0]                                   activeSource1,
	output logic [2:0]                                   activeSource2
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		sync_trig_pkg::src_e             src1;
		sync_trig_pkg::src_e             src2;
		logic [1:0]                      pinLast;
		logic [sync_trig_pkg::TMR_W-1:0] interval;
		logic [sync_trig_pkg::TMR_W-1:0] delay;
		logic                            delayRun;
		logic [1:0]                      tick;
		logic [1:0]                      busy;
		logic [1:0]                      fault;
		logic [1:0]                      pulse;
	} top_s;

	top_s cur;
	top_s next_cur;
	logic [1:0] chBusy;
	logic [1:0] chFault;
	logic [1:0] chPulse;
	logic [1:0] pinRise;
	logic [1:0] bufReset;

	function automatic sync_trig_pkg::src_e to_src(input logic [2:0] v);
		// Unknown codes fall back to the startup source
		if (v > 3'h4)
			return sync_trig_pkg::SRC_RESET;
		return sync_trig_pkg::src_e'(v);
	endfunction

	// ------------------------------------------------------------
	// Interval timer and edge detect
	// ------------------------------------------------------------
	always_comb begin
		next_cur = cur;
		// Pins are taken as synchronous; rising edges only
		pinRise = {triggerPinTwo & ~cur.pinLast[1],
			triggerPinOne & ~cur.pinLast[0]};
		next_cur.pinLast = {triggerPinTwo, triggerPinOne};
		bufReset[0] = deviceControlWrite &&
			deviceControlReg == sync_trig_pkg::RESET_CH1;
		bufReset[1] = deviceControlWrite &&
			deviceControlReg == sync_trig_pkg::RESET_CH2;
		if (configWrite) begin
			next_cur.src1 = to_src(configSource1);
			next_cur.src2 = to_src(configSource2);
		end
		next_cur.tick = 2'b00;
		// Channel one tick every interval; channel two delayed
		if (cur.interval == '0) begin
			// Reload one short so ticks are exactly the interval apart
			next_cur.interval = (pulseIntervalTimerReg != '0) ?
				pulseIntervalTimerReg - 16'h0001 : '0;
			next_cur.tick[0]  = (pulseIntervalTimerReg != '0);
			next_cur.delay    = interChannelPulseDelay;
			next_cur.delayRun = (pulseIntervalTimerReg != '0);
		end else begin
			next_cur.interval = cur.interval - 1'b1;
		end
		if (cur.delayRun) begin
			if (cur.delay == '0) begin
				next_cur.tick[1]  = 1'b1;
				next_cur.delayRun = 1'b0;
			end else begin
				next_cur.delay = cur.delay - 1'b1;
			end
		end
		next_cur.busy  = chBusy;
		next_cur.fault = chFault;
		next_cur.pulse = chPulse;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cur <= '{default: '0,
				src1: sync_trig_pkg::SRC_RESET,
				src2: sync_trig_pkg::SRC_RESET};
		end else begin
			cur <= next_cur;
		end
	end

	// ------------------------------------------------------------
	// Channels
	// ------------------------------------------------------------
	pulse_channel ch1 (
		.clk         (clk),
		.rst         (rst),
		.source      (cur.src1),
		.widthMode   (gapOrWidthSelect[0]),
		.newRevision (newRevision),
		.extLong     (channelLongPulse[0]),
		.filterTime  (pulseIntervalTimerReg),
		.bufWrite    (bufferWrite[0]),
		.bufData     (bufferData),
		.readyConfirm(upstreamReadyConfirm[0]),
		.confirmLen  (confirmLength),
		.bufReset    (bufReset[0]),
		.faultClear  (faultClear[0]),
		.cmdTrig     (commandTrigger[0]),
		.pinRise     (pinRise[0]),
		.timerTick   (cur.tick[0]),
		.busy        (chBusy[0]),
		.fault       (chFault[0]),
		.pulseActive (chPulse[0])
	);

	pulse_channel ch2 (
		.clk         (clk),
		.rst         (rst),
		.source      (cur.src2),
		.widthMode   (gapOrWidthSelect[1]),
		.newRevision (newRevision),
		.extLong     (channelLongPulse[1]),
		.filterTime  (pulseIntervalTimerReg),
		.bufWrite    (bufferWrite[1]),
		.bufData     (bufferData),
		.readyConfirm(upstreamReadyConfirm[1]),
		.confirmLen  (confirmLength),
		.bufReset    (bufReset[1]),
		.faultClear  (faultClear[1]),
		.cmdTrig     (commandTrigger[1]),
		.pinRise     (pinRise[1]),
		.timerTick   (cur.tick[1]),
		.busy        (chBusy[1]),
		.fault       (chFault[1]),
		.pulseActive (chPulse[1])
	);

	// Flag and pulse outputs registered one cycle after the channel state
	assign upstreamBusyFlag   = cur.busy;
	assign upstreamWriteFault = cur.fault;
	assign syncPulse          = cur.pulse;
	assign receiverFreeze     = cur.pulse;
	assign activeSource1      = cur.src1;
	assign activeSource2      = cur.src2;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_freeze_follows: assert property (@(posedge clk)
		disable iff (rst) receiverFreeze == $past(chPulse))
		else $error("receiver not frozen during pulse");
	chk_default_source: assert property (@(posedge clk)
		$past(rst) |-> activeSource1 == 3'h2)
		else $error("startup source is not pin without buffer");
	chk_default_source2: assert property (@(posedge clk)
		$past(rst) |-> activeSource2 == 3'h2)
		else $error("startup source two is not pin without buffer");
	chk_busy_mirror: assert property (@(posedge clk)
		disable iff (rst) upstreamBusyFlag == $past(chBusy))
		else $error("busy flag does not follow channel");
	chk_fault_mirror: assert property (@(posedge clk)
		disable iff (rst) upstreamWriteFault == $past(chFault))
		else $error("fault flag does not follow channel");
	chk_reset_word: assert property (@(posedge clk)
		disable iff (rst)
		deviceControlWrite && deviceControlReg == sync_trig_pkg::RESET_CH1
		|=> ##1 !upstreamBusyFlag[0])
		else $error("channel one not ready after reset word");
	chk_reset_word2: assert property (@(posedge clk)
		disable iff (rst)
		deviceControlWrite && deviceControlReg == sync_trig_pkg::RESET_CH2
		|=> ##1 !upstreamBusyFlag[1])
		else $error("channel two not ready after reset word");
	chk_src_fallback: assert property (@(posedge clk)
		disable iff (rst)
		configWrite && configSource1 > 3'h4 |=> activeSource1 == 3'h2)
		else $error("unknown source code not mapped to pin mode");
	chk_tick_delay: assert property (@(posedge clk)
		disable iff (rst)
		cur.tick[0] && interChannelPulseDelay == '0 |=> cur.tick[1])
		else $error("channel two tick not delayed as set");
	chk_tick_spacing: assert property (@(posedge clk)
		disable iff (rst)
		cur.tick[0] && $past(pulseIntervalTimerReg) > 16'h0001
		|=> !cur.tick[0])
		else $error("timer ticks closer than the interval");
endmodule
`default_nettype wire

// File: sim/host_model.sv
// Microcontroller model: configures, loads, confirms and triggers
`timescale 1ns/1ps
`default_nettype none
module host_model (
	// Clock
	input  wire logic   clk,
	// Configuration
	output logic        configWrite,
	output logic [2:0]  configSource1,
	output logic [2:0]  configSource2,
	output logic [1:0]  gapOrWidthSelect,
	output logic        newRevision,
	output logic [1:0]  channelLongPulse,
	output logic [15:0] pulseIntervalTimerReg,
	output logic [15:0] interChannelPulseDelay,
	// Control word
	output logic        deviceControlWrite,
	output logic [15:0] deviceControlReg,
	// Buffer load
	output logic [1:0]  bufferWrite,
	output logic [63:0] bufferData,
	output logic [1:0]  upstreamReadyConfirm,
	output logic [6:0]  confirmLength,
	output logic [1:0]  faultClear,
	// Triggers
	output logic [1:0]  commandTrigger,
	output logic        triggerPinOne,
	output logic        triggerPinTwo
);
	initial begin
		{configWrite, configSource1, configSource2, gapOrWidthSelect} = '0;
		{newRevision, channelLongPulse, pulseIntervalTimerReg} = '0;
		{interChannelPulseDelay, deviceControlWrite, deviceControlReg} = '0;
		{bufferWrite, bufferData, upstreamReadyConfirm, confirmLength} = '0;
		{faultClear, commandTrigger, triggerPinOne, triggerPinTwo} = '0;
	end
	task automatic setup(input int s1, s2, gw, rev, lp, ivl, dly);
		@(posedge clk);
		configSource1 <= 3'(s1);
		configSource2 <= 3'(s2);
		gapOrWidthSelect <= 2'(gw);
		newRevision <= 1'(rev);
		channelLongPulse <= 2'(lp);
		pulseIntervalTimerReg <= 16'(ivl);
		interChannelPulseDelay <= 16'(dly);
		configWrite <= 1'b1;
		@(posedge clk);
		configWrite <= 1'b0;
	endtask
	// Message goes out as framed here, check bits included
	task automatic write(input int ch, input logic [63:0] data);
		@(posedge clk);
		bufferData <= data;
		bufferWrite[ch] <= 1'b1;
		@(posedge clk);
		bufferWrite[ch] <= 1'b0;
	endtask
	// Confirm only after the buffer is written
	task automatic load(input int ch, input logic [63:0] data, input int n);
		write(ch, data);
		confirmLength <= 7'(n);
		upstreamReadyConfirm[ch] <= 1'b1;
		@(posedge clk);
		upstreamReadyConfirm[ch] <= 1'b0;
	endtask
	task automatic trig(input int ch);
		@(posedge clk);
		commandTrigger[ch] <= 1'b1;
		@(posedge clk);
		commandTrigger[ch] <= 1'b0;
	endtask
	task automatic ctrl(input logic [15:0] w);
		@(posedge clk);
		deviceControlReg <= w;
		deviceControlWrite <= 1'b1;
		@(posedge clk);
		deviceControlWrite <= 1'b0;
	endtask
	task automatic clear(input int ch);
		@(posedge clk);
		faultClear[ch] <= 1'b1;
		@(posedge clk);
		faultClear[ch] <= 1'b0;
	endtask
	// Pin driven to the given level at the next edge and left there
	task automatic pin(input int ch, input logic v);
		@(posedge clk);
		if (ch == 0)
			triggerPinOne <= v;
		else
			triggerPinTwo <= v;
	endtask
endmodule
`default_nettype wire

// File: sim/sync_pulse_downlink_trigger_tb_top.sv
// Self-checking bench for the two-channel downlink sync trigger block
`timescale 1ns/1ps
`default_nettype none
module sync_pulse_downlink_trigger_tb_top;
	localparam int SHORT = sync_trig_pkg::SHORT_CYCLES;
	localparam int LONG  = sync_trig_pkg::LONG_CYCLES;
	logic        clk, rst, configWrite, newRevision, deviceControlWrite;
	logic        triggerPinOne, triggerPinTwo;
	logic [2:0]  configSource1, configSource2, activeSource1, activeSource2;
	logic [1:0]  gapOrWidthSelect, channelLongPulse, bufferWrite, faultClear;
	logic [1:0]  upstreamReadyConfirm, commandTrigger, upstreamBusyFlag;
	logic [1:0]  upstreamWriteFault, syncPulse, receiverFreeze;
	logic [15:0] pulseIntervalTimerReg, interChannelPulseDelay;
	logic [15:0] deviceControlReg;
	logic [63:0] bufferData, d;
	logic [6:0]  confirmLength;
	int          fails, checks, n, k, len, t;

	sync_pulse_downlink_trigger i_dut (
		.clk, .rst, .configWrite, .configSource1, .configSource2,
		.gapOrWidthSelect, .newRevision, .channelLongPulse,
		.pulseIntervalTimerReg, .interChannelPulseDelay, .deviceControlWrite,
		.deviceControlReg, .bufferWrite, .bufferData, .upstreamReadyConfirm,
		.confirmLength, .faultClear, .commandTrigger, .triggerPinOne,
		.triggerPinTwo, .upstreamBusyFlag, .upstreamWriteFault, .syncPulse,
		.receiverFreeze, .activeSource1, .activeSource2
	);
	host_model i_host (
		.clk, .configWrite, .configSource1, .configSource2,
		.gapOrWidthSelect, .newRevision, .channelLongPulse,
		.pulseIntervalTimerReg, .interChannelPulseDelay, .deviceControlWrite,
		.deviceControlReg, .bufferWrite, .bufferData, .upstreamReadyConfirm,
		.confirmLength, .faultClear, .commandTrigger, .triggerPinOne,
		.triggerPinTwo
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [63:0] seen, exp, input string what);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR at %0t: %s seen %0h expected %0h",
				$time, what, seen, exp);
		end
	endtask
	task automatic step(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	// Edges to the next rise of a pulse line, limit+1 when none
	task automatic waitRise(input int ch, limit, output int cnt);
		logic p;
		p = syncPulse[ch];
		for (cnt = 1; cnt <= limit; cnt++) begin
			step(1);
			if (!p && syncPulse[ch] === 1'b1)
				break;
			p = syncPulse[ch];
		end
	endtask
	task automatic measure(input int ch, output int w);
		int r;
		waitRise(ch, 16, r);
		w = 0;
		if (r <= 16) begin
			check(receiverFreeze[ch], 1'b1, "receiver freeze");
			while (syncPulse[ch] === 1'b1 && w < 1100) begin
				w++;
				step(1);
			end
		end
	endtask
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		fails = 0;
		checks = 0;
		rst = 1'b1;
		void'($urandom(32'h0e36));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		step(2);
		check(activeSource1, 3'h2, "default source");
		check({upstreamBusyFlag, upstreamWriteFault, syncPulse}, 0, "idle");
		$display("reset test done");
		for (k = 0; k < 6; k++) begin
			i_host.setup(k, 5 - k, 0, 0, 0, 0, 0);
			step(3);
			check(activeSource1, k > 4 ? 2 : k, "source one");
			check(activeSource2, k < 1 ? 2 : 5 - k, "source two");
		end
		$display("source test done");
		i_host.setup(1, 1, 0, 0, 0, 0, 0);
		for (k = 0; k < 2; k++) begin
			d = {$urandom, $urandom};
			n = 2 + $urandom % 3;
			i_host.load(k, d, n);
			for (int i = 0; i < n; i++) begin
				step(3);
				check(upstreamBusyFlag[k], 1'b1, "busy held");
				i_host.trig(k);
				measure(k, len);
				check(len, d[63 - i] ? SHORT : 0, "gap pulse");
				check(syncPulse[1 - k], 1'b0, "other quiet");
			end
			check(upstreamBusyFlag[k], 1'b0, "busy after send");
			i_host.trig(k);
			measure(k, len);
			check(len, SHORT, "empty buffer pulse");
		end
		$display("stream test done");
		i_host.load(0, '1, 5);
		i_host.load(1, '0, 5);
		i_host.write(0, '0);
		step(3);
		check(upstreamWriteFault, 2'b01, "write while busy");
		i_host.ctrl(sync_trig_pkg::RESET_CH2);
		step(3);
		check(upstreamBusyFlag, 2'b01, "second reset");
		i_host.ctrl(sync_trig_pkg::RESET_CH1);
		i_host.clear(0);
		step(3);
		check(upstreamBusyFlag, 2'b00, "first reset");
		check(upstreamWriteFault, 2'b00, "fault cleared");
		i_host.setup(1, 1, 0, 0, 0, 300, 0);
		i_host.load(1, '1, 3);
		i_host.trig(1);
		step(10);
		i_host.trig(1);
		step(3);
		check(upstreamWriteFault, 2'b10, "trigger while busy");
		i_host.ctrl(sync_trig_pkg::RESET_CH2);
		i_host.clear(1);
		step(600);
		$display("fault test done");
		i_host.setup(1, 1, 3, 1, 0, 0, 0);
		i_host.load(0, {2'b10, 62'h0}, 2);
		for (k = 0; k < 2; k++) begin
			i_host.trig(0);
			measure(0, len);
			check(len, k == 0 ? LONG : SHORT, "width pulse");
		end
		i_host.setup(0, 0, 0, 1, 1, 0, 0);
		for (k = 0; k < 2; k++) begin
			i_host.trig(k);
			measure(k, len);
			check(len, k == 0 ? LONG : SHORT, "external width");
		end
		i_host.setup(2, 2, 0, 0, 0, 0, 0);
		for (k = 0; k < 2; k++) begin
			fork
				begin
					i_host.pin(k, 1'b1);
					step(100);
					i_host.pin(k, 1'b0);
				end
				measure(k, len);
			join
			check(len, SHORT, "pin pulse");
		end
		$display("encoding test done");
		t = 10 + $urandom % 100;
		i_host.setup(4, 4, 0, 0, 0, 600, t);
		waitRise(0, 2000, n);
		waitRise(1, 2000, n);
		check(n, t + 1, "channel delay");
		waitRise(0, 2000, n);
		check(n, 600 - t - 1, "timer interval");
		// Corner case: zero inter-channel delay, channel two one cycle behind
		i_host.setup(4, 4, 0, 0, 0, 600, 0);
		waitRise(0, 2000, n);
		waitRise(1, 2000, n);
		check(n, 1, "zero channel delay");
		i_host.setup(2, 2, 0, 0, 0, 0, 0);
		$display("timer test done");
		final_report();
	end

	initial begin
		#400000;
		fails++;
		$display("ERROR at %0t: watchdog expired", $time);
		final_report();
	end
endmodule
`default_nettype wire
